// ### inc/sdp_pkg.sv
// package for the sdram pin interface: commands, timing counts, carriers
// assumes a single 125 MHz ref_clk domain
package sdp_pkg;

    // command encoding on {row, column, write} strobes, active low
    localparam logic [2:0] CMD_NOP       = 3'h7;
    localparam logic [2:0] CMD_ACTIVE    = 3'h3;
    localparam logic [2:0] CMD_READ      = 3'h5;
    localparam logic [2:0] CMD_WRITE     = 3'h4;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_REFRESH   = 3'h1;
    localparam logic [2:0] CMD_MODE      = 3'h0;

    // timing in its own unit, then cycles at the ref clock rate
    localparam int CLK_PERIOD_PS    = 8000;
    localparam int INIT_WAIT_NS     = 200;
    localparam int INIT_WAIT_CYC    = (INIT_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int INIT_REFRESHES   = 2;
    localparam int CMD_GAP_CYC      = 4;
    localparam int MEM_CLK_DIV      = 2;

    // pin levels after reset release
    localparam logic RST_STROBE_LVL = 1'h1;
    localparam logic RST_MASK_LVL   = 1'h1;
    localparam logic RST_CKE_LVL    = 1'h1;

    typedef enum logic [1:0] {
        REQ_READ,
        REQ_WRITE,
        REQ_REFRESH,
        REQ_SELF_REFRESH
    } sdp_req_e;

    // request from the core side
    typedef struct packed {
        sdp_req_e    kind;
        logic [12:0] row;
        logic        a10;
    } sdp_req_s;

    // registered command pins
    typedef struct packed {
        logic rowStrobeN;
        logic columnStrobeN;
        logic writeStrobeN;
        logic clockEnable;
        logic dataMask;
        logic a10;
        logic a10Drive;
    } sdp_pins_s;

endpackage

// ### rtl/sdp_clk_div.sv
// memory clock divider: toggles the clock pin and issues an update enable
// assumes ref_clk domain, synchronous active-high reset
`timescale 1ns/10ps
module sdp_clk_div #(
    parameter int DIV = sdp_pkg::MEM_CLK_DIV
) (
    input  wire logic ref_clk,      // reference clock
    input  wire logic sys_rst,      // synchronous reset
    input  wire logic run,          // clock runs while high
    output logic      memClk,       // memory clock level
    output logic      fallEn        // pulse just before falling edge
);
    localparam int CW = $clog2(DIV) + 1;
    logic [CW-1:0] cnt_q;

    // half period counter; stops low when not running to save switching
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !run) begin
            cnt_q  <= '0;
            memClk <= 1'b0;
        end else if (cnt_q == CW'(DIV/2 - 1) || DIV < 2) begin
            cnt_q  <= '0;
            memClk <= !memClk;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // pins update on the falling edge so the memory samples them stable at rise
    assign fallEn = run && memClk && (cnt_q == CW'(DIV/2 - 1) || DIV < 2);
endmodule

// ### rtl/sdp_ctrl.sv
// sdram pin controller: init sequence, command strobes, mask, clock enable
// assumes requests from logic on ref_clk; no software-reachable registers
`timescale 1ns/10ps

// Function
// - strobes together encode each memory command
// - dedicated a10 driven only during accesses
// - refresh may overlap non-sdram accesses
// - mask high from reset until init done
// - mask low always after init
// - clock enable gates memory clock, self refresh
// - disable bit stops interface switching
module sdp_ctrl #(
    parameter int INIT_CYC = sdp_pkg::INIT_WAIT_CYC
) (
    input  wire logic             ref_clk,               // 125 MHz clock
    input  wire logic             sys_rst,               // synchronous reset
    input  wire logic             interface_disable_bit, // stop the interface
    input  wire logic             reqValid,              // request present
    input  wire sdp_pkg::sdp_req_s reqData,              // request content
    output logic                  reqReady,              // request accepted
    output logic                  initDone,              // init complete
    output logic                  row_strobe_out,        // row strobe, low active
    output logic                  column_strobe_out,     // column strobe, low active
    output logic                  write_strobe_out,      // write strobe, low active
    output logic                  mem_clock_enable_out,  // memory clock enable
    output logic                  data_mask_out,         // data mask
    output logic                  precharge_addr_bit_out,// dedicated a10 value
    output logic                  precharge_addr_bit_oe, // a10 pin driven
    output logic                  mem_clock_out          // memory clock
);
    typedef enum logic [2:0] {
        ST_WAIT, ST_PRE, ST_REF, ST_MODE, ST_IDLE, ST_GAP, ST_SELF
    } sdp_state_e;

    sdp_state_e        state_q;
    sdp_pkg::sdp_pins_s pins_q;
    logic [15:0]       cnt_q;
    logic [1:0]        refCnt_q;
    logic              fallEn;
    logic              memClk;

    sdp_clk_div #(.DIV(sdp_pkg::MEM_CLK_DIV)) u_div (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .run     (!interface_disable_bit),
        .memClk  (memClk),
        .fallEn  (fallEn)
    );

    // command issued as one registered strobe pattern
    function automatic logic [2:0] cmdOf(input sdp_pkg::sdp_req_e k);
        case (k)
            sdp_pkg::REQ_READ:    cmdOf = sdp_pkg::CMD_READ;
            sdp_pkg::REQ_WRITE:   cmdOf = sdp_pkg::CMD_WRITE;
            default:              cmdOf = sdp_pkg::CMD_REFRESH;
        endcase
    endfunction

    assign reqReady = (state_q == ST_IDLE || state_q == ST_SELF) && fallEn;

    // sequencer: init, then single commands separated by a gap
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q  <= ST_WAIT;
            cnt_q    <= '0;
            refCnt_q <= '0;
            pins_q   <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        end else if (fallEn) begin
            // defaults: nop, a10 pin released so shared address may use it
            {pins_q.rowStrobeN, pins_q.columnStrobeN, pins_q.writeStrobeN} <= sdp_pkg::CMD_NOP;
            pins_q.a10Drive <= 1'b0;
            case (state_q)
                ST_WAIT: begin
                    // one update slot lasts MEM_CLK_DIV reference cycles
                    if (cnt_q >= 16'(INIT_CYC / sdp_pkg::MEM_CLK_DIV)) begin
                        state_q <= ST_PRE;
                        {pins_q.rowStrobeN, pins_q.columnStrobeN, pins_q.writeStrobeN}
                            <= sdp_pkg::CMD_PRECHARGE;
                        pins_q.a10      <= 1'b1;  // all banks
                        pins_q.a10Drive <= 1'b1;
                        cnt_q           <= '0;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                ST_PRE, ST_REF: begin
                    if (cnt_q == 16'(sdp_pkg::CMD_GAP_CYC)) begin
                        cnt_q <= '0;
                        if (refCnt_q == 2'(sdp_pkg::INIT_REFRESHES)) begin
                            state_q <= ST_MODE;
                            {pins_q.rowStrobeN, pins_q.columnStrobeN, pins_q.writeStrobeN}
                                <= sdp_pkg::CMD_MODE;
                            pins_q.a10Drive <= 1'b1;
                            pins_q.a10      <= 1'b0;
                        end else begin
                            state_q  <= ST_REF;
                            refCnt_q <= refCnt_q + 2'h1;
                            {pins_q.rowStrobeN, pins_q.columnStrobeN, pins_q.writeStrobeN}
                                <= sdp_pkg::CMD_REFRESH;
                        end
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                ST_MODE: begin
                    if (cnt_q == 16'(sdp_pkg::CMD_GAP_CYC)) begin
                        state_q         <= ST_IDLE;
                        pins_q.dataMask <= 1'b0;
                        cnt_q           <= '0;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                ST_IDLE: begin
                    if (reqValid && reqData.kind == sdp_pkg::REQ_SELF_REFRESH) begin
                        // self refresh: refresh with clock enable dropped
                        {pins_q.rowStrobeN, pins_q.columnStrobeN, pins_q.writeStrobeN}
                            <= sdp_pkg::CMD_REFRESH;
                        pins_q.clockEnable <= 1'b0;
                        state_q            <= ST_SELF;
                    end else if (reqValid) begin
                        // refresh owns only the dedicated a10, so shared bus stays free
                        {pins_q.rowStrobeN, pins_q.columnStrobeN, pins_q.writeStrobeN}
                            <= cmdOf(reqData.kind);
                        pins_q.a10      <= reqData.a10;
                        pins_q.a10Drive <= 1'b1;
                        state_q         <= ST_GAP;
                        cnt_q           <= '0;
                    end
                end
                ST_GAP: begin
                    if (cnt_q == 16'(sdp_pkg::CMD_GAP_CYC)) begin
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                ST_SELF: begin
                    // any request wakes the memory by raising clock enable
                    if (reqValid) begin
                        pins_q.clockEnable <= 1'b1;
                        state_q            <= ST_GAP;
                        cnt_q              <= '0;
                    end
                end
                default: state_q <= ST_WAIT;
            endcase
        end
    end

    // outputs; with the interface disabled the divider halts and pins freeze
    assign initDone               = (state_q == ST_IDLE) || (state_q == ST_GAP)
                                    || (state_q == ST_SELF);
    assign row_strobe_out         = pins_q.rowStrobeN;
    assign column_strobe_out      = pins_q.columnStrobeN;
    assign write_strobe_out       = pins_q.writeStrobeN;
    assign mem_clock_enable_out   = pins_q.clockEnable;
    assign data_mask_out          = pins_q.dataMask;
    assign precharge_addr_bit_out = pins_q.a10;
    assign precharge_addr_bit_oe  = pins_q.a10Drive;
    assign mem_clock_out          = memClk;

    // mask stays high for the whole init phase
    mask_init_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !initDone |-> data_mask_out) else $error("mask low before init done");

    // once low, mask never rises again
    mask_after_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        initDone |-> !data_mask_out) else $error("mask high after init");

    // pins only change on divider update enable
    pins_sync_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(fallEn) && !$past(sys_rst) |-> $stable(pins_q))
        else $error("pins changed off clock edge");

    // a10 driven only with a command other than nop
    a10_drive_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        precharge_addr_bit_oe |-> {row_strobe_out, column_strobe_out, write_strobe_out}
        != sdp_pkg::CMD_NOP) else $error("a10 driven without access");

    // clock toggles within a few cycles when enabled
    clk_run_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !interface_disable_bit [*4]
        |-> (memClk != $past(memClk)) || ($past(memClk) != $past(memClk, 2)))
        else $error("memory clock not running");

    // disabled interface stops the clock
    clk_stop_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        interface_disable_bit |=> !mem_clock_out) else $error("clock runs while disabled");

    // clock enable stays low for as long as the sequencer is in self refresh
    cke_self_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == ST_SELF |-> !mem_clock_enable_out) else $error("cke high in self refresh");

    // accepted read issues read command next update
    read_cmd_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reqReady && reqValid && state_q == ST_IDLE && reqData.kind == sdp_pkg::REQ_READ
        |=> {row_strobe_out, column_strobe_out, write_strobe_out} == sdp_pkg::CMD_READ)
        else $error("read command not encoded");
endmodule

// ### tb/sdp_mem_model.sv
// behavioural memory at the far side of the sdram command pins
// assumes commands are sampled on the rising memory clock edge while enabled
`timescale 1ns/10ps
module sdp_mem_model (
    input  wire logic       memClk,   // memory clock
    input  wire logic       cke,      // clock enable
    input  wire logic [2:0] cmd,      // row, column, write strobes
    input  wire logic       dqm,      // data mask
    output logic [7:0]      nRefresh, // refreshes seen
    output logic [7:0]      nMode,    // mode loads seen
    output logic [7:0]      nWrite,   // writes accepted
    output logic            dqDrive   // output buffers on
);
    initial begin
        nRefresh = 8'h00;
        nMode = 8'h00;
        nWrite = 8'h00;
        dqDrive = 1'b0;
    end

    // clock gated by cke: nothing is decoded while it is low
    always @(posedge memClk) begin
        if (cke) begin
            if (cmd == sdp_pkg::CMD_REFRESH) nRefresh <= nRefresh + 8'h01;
            if (cmd == sdp_pkg::CMD_MODE) nMode <= nMode + 8'h01;
            if (cmd == sdp_pkg::CMD_WRITE && !dqm) nWrite <= nWrite + 8'h01;
            dqDrive <= (cmd == sdp_pkg::CMD_READ) && !dqm;
        end
    end
endmodule

// ### tb/test_sdram_pin_interface.sv
// bench for the sdram pin controller: init, commands, self refresh, disable
// assumes sdp_pkg and the memory model are compiled first
`timescale 1ns/10ps
module test_sdram_pin_interface;
    logic ref_clk = 1'b0, sys_rst = 1'b1, interface_disable_bit = 1'b0, reqValid = 1'b0;
    sdp_pkg::sdp_req_s reqData = '0;
    logic reqReady, initDone, row_strobe_out, column_strobe_out, write_strobe_out;
    logic mem_clock_enable_out, data_mask_out, precharge_addr_bit_out, precharge_addr_bit_oe;
    logic mem_clock_out, dqDrive;
    logic [7:0] nRefresh, nMode, nWrite;
    wire  [2:0] cmdNow = {row_strobe_out, column_strobe_out, write_strobe_out};
    int failures = 0, n_compared = 0;

    sdp_ctrl #(.INIT_CYC(4)) i_sdp_ctrl (.ref_clk, .sys_rst, .interface_disable_bit,
        .reqValid, .reqData, .reqReady, .initDone, .row_strobe_out, .column_strobe_out,
        .write_strobe_out, .mem_clock_enable_out, .data_mask_out, .precharge_addr_bit_out,
        .precharge_addr_bit_oe, .mem_clock_out);
    sdp_mem_model i_sdp_mem_model (.memClk(mem_clock_out), .cke(mem_clock_enable_out),
        .cmd(cmdNow), .dqm(data_mask_out), .nRefresh, .nMode, .nWrite, .dqDrive);

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // request held from a falling edge until the rising edge that takes it
    task automatic issue(input sdp_pkg::sdp_req_e kind, input logic a10);
        int i;
        @(negedge ref_clk);
        reqValid = 1'b1;
        reqData = '{kind: kind, row: 13'h0ABC, a10: a10};
        #1;
        for (i = 0; i < 60 && reqReady !== 1'b1; i++) begin
            @(negedge ref_clk);
            #1;
        end
        check(reqReady, 1'b1);
        @(posedge ref_clk);
        @(negedge ref_clk);
        reqValid = 1'b0;
    endtask

    // counts memory clock changes over sixteen reference cycles
    task automatic clock_edges(output int n);
        logic last;
        n = 0;
        last = mem_clock_out;
        repeat (16) begin
            @(negedge ref_clk);
            if (mem_clock_out !== last) n++;
            last = mem_clock_out;
        end
    endtask

    task automatic t_reset();
        repeat (3) @(negedge ref_clk);
        check(cmdNow, sdp_pkg::CMD_NOP);
        check({mem_clock_enable_out, data_mask_out, precharge_addr_bit_oe}, 3'h6);
        @(negedge ref_clk);
        sys_rst = 1'b0;
    endtask

    task automatic t_init();
        int i;
        for (i = 0; i < 400 && initDone !== 1'b1; i++) begin
            check(data_mask_out, 1'b1);
            @(negedge ref_clk);
        end
        check(initDone, 1'b1);
        check(nRefresh, sdp_pkg::INIT_REFRESHES);
        check(nMode, 8'h01);
        check(data_mask_out, 1'b0);
    endtask

    // each access kind: strobes, dedicated a10 driven, then released
    task automatic t_cmds();
        sdp_pkg::sdp_req_e k[3] = '{sdp_pkg::REQ_READ, sdp_pkg::REQ_WRITE, sdp_pkg::REQ_REFRESH};
        logic [2:0] e[3] = '{sdp_pkg::CMD_READ, sdp_pkg::CMD_WRITE, sdp_pkg::CMD_REFRESH};
        for (int j = 0; j < 3; j++) begin
            issue(k[j], j[0]);
            check(cmdNow, e[j]);
            check(precharge_addr_bit_oe, 1'b1);
            if (j < 2) check(precharge_addr_bit_out, j[0]);
            // memory has seen the command on its rising clock by now
            @(negedge ref_clk);
            check(dqDrive, j == 0);
            repeat (5) @(negedge ref_clk);
            check(cmdNow, sdp_pkg::CMD_NOP);
            check(precharge_addr_bit_oe, 1'b0);
            check(data_mask_out, 1'b0);
        end
        check(nWrite, 8'h01);
        check(nRefresh, sdp_pkg::INIT_REFRESHES + 1);
    endtask

    task automatic t_self();
        int i;
        issue(sdp_pkg::REQ_SELF_REFRESH, 1'b0);
        for (i = 0; i < 8 && mem_clock_enable_out !== 1'b0; i++) @(negedge ref_clk);
        check(mem_clock_enable_out, 1'b0);
        issue(sdp_pkg::REQ_READ, 1'b0);
        for (i = 0; i < 8 && mem_clock_enable_out !== 1'b1; i++) @(negedge ref_clk);
        check(mem_clock_enable_out, 1'b1);
    endtask

    // memory clock toggles every DIV/2 reference cycles, so 32/DIV changes in 16
    task automatic t_disable();
        int n;
        clock_edges(n);
        check(n, 32 / sdp_pkg::MEM_CLK_DIV);
        interface_disable_bit = 1'b1;
        repeat (4) @(negedge ref_clk);
        clock_edges(n);
        check(n, 0);
        check({mem_clock_out, cmdNow}, 4'h7);
        interface_disable_bit = 1'b0;
        repeat (4) @(negedge ref_clk);
        clock_edges(n);
        check(n, 32 / sdp_pkg::MEM_CLK_DIV);
    endtask

    task automatic give_verdict();
        if (failures == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        #(8 * 5000);
        failures++;
        give_verdict();
    end

    initial begin
        t_reset();
        t_init();
        t_cmds();
        t_self();
        t_disable();
        give_verdict();
    end
endmodule
